// >>> core/swrtc_slave.sv
// Purpose: Slave end of a single-wire open-drain link for a seconds clock.
// Assumes: sec_tick is a one-cycle pulse per second on clk; the line is
//          pulled up outside; rst_n comes only from the battery supply.
// Notes:   Slot timing is measured from the synchronised falling edge.
`timescale 1ns/100ps
module swrtc_slave
    import swrtc_pkg::*;
#(
    // Identity value is arbitrary
    parameter logic [63:0] DEV_ID = 64'h5AC3_0000_0001_2345,
    parameter logic [TW-1:0] RESET_CYC = TW'(RESET_DET_CYC),
    parameter logic [TW-1:0] PRES_CYC = TW'(PRES_LOW_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dq_in,
    output logic dq_out,
    output logic dq_oe_n,
    input wire logic sec_tick,
    output logic [31:0] rtc_count,
    output logic osc_run,
    output logic [3:0] user_flag_bits
);

    swrtc_regs_t q;
    swrtc_regs_t d;
    swrtc_buf_req_t req;
    logic [7:0] buf_rdata;
    logic [31:0] buf_word;
    logic fall;
    logic tx_mode;
    logic tx_bit;
    logic slot_end;
    logic rx_bit;
    logic [7:0] rx_byte;
    logic rx_done;
    logic byte_st;
    logic slotted;
    logic id_bit;
    logic long_low;
    logic [7:0] ctrl_byte;

    swrtc_shadow u_shadow (
        .clk(clk),
        .rst_n(rst_n),
        .req(req),
        .rdata(buf_rdata),
        .word(buf_word)
    );

    always_comb begin
        d = q;
        req = '0;
        req.snap_val = q.rtc;
        req.raddr = 2'(q.bnum - 3'h1);
        ctrl_byte = {q.flags, q.osc, q.osc, 2'b00};
        d.dq_s1 = dq_in;
        d.dq_s2 = q.dq_s1;
        d.dq_prev = q.dq_s2;
        d.dq_out = 1'b0;
        fall = q.dq_prev && !q.dq_s2;
        id_bit = DEV_ID[q.bidx];
        rx_bit = q.dq_s2;
        rx_byte = {rx_bit, q.sh[7:1]};
        long_low = !q.dq_s2 && q.low_cnt == RESET_CYC - TW'(1);
        // Oscillator off leaves the counter as plain storage
        if (sec_tick && q.osc) begin
            d.rtc = q.rtc + 32'h0000_0001;
        end
        if (q.dq_s2) begin
            d.low_cnt = '0;
        end else if (q.low_cnt != RESET_CYC) begin
            d.low_cnt = q.low_cnt + TW'(1);
        end
        tx_mode = q.st == ST_ROM_READ || q.st == ST_READ_CLK ||
                  (q.st == ST_SEARCH && q.sub != 2'h2);
        if (q.st == ST_READ_CLK) begin
            tx_bit = q.sh[0];
        end else begin
            tx_bit = id_bit ^ (q.sub == 2'h1);
        end
        slot_end = q.in_slot &&
                   q.tcnt == (tx_mode ? HOLD_CYC : SAMPLE_CYC);
        rx_done = slot_end && !tx_mode && q.bcnt == 3'h7;
        byte_st = q.st == ST_ROM_CMD || q.st == ST_FUNC_CMD ||
                  q.st == ST_READ_CLK || q.st == ST_WRITE_CLK;
        slotted = byte_st || q.st == ST_ROM_READ || q.st == ST_ROM_MATCH ||
                  q.st == ST_SEARCH;

        // Own low drive cannot retrigger: no new slot while one is open
        if (slotted && fall && !q.in_slot) begin
            d.in_slot = 1'b1;
            d.tcnt = '0;
            d.oe_n = !(tx_mode && !tx_bit);
        end else if (q.in_slot) begin
            d.tcnt = q.tcnt + TW'(1);
            if (slot_end) begin
                d.in_slot = 1'b0;
                d.oe_n = 1'b1;
                if (byte_st) begin
                    d.bcnt = q.bcnt + 3'h1;
                    d.sh = tx_mode ? {q.sh[0], q.sh[7:1]} : rx_byte;
                end
            end
        end

        case (q.st)
            ST_IDLE: begin
            end
            ST_RST_LOW: begin
                if (q.dq_s2) begin
                    d.st = ST_PRES_WAIT;
                    d.tcnt = '0;
                end
            end
            ST_PRES_WAIT: begin
                d.tcnt = q.tcnt + TW'(1);
                if (q.tcnt == PRES_WAIT_CYC - TW'(1)) begin
                    d.st = ST_PRES_LOW;
                    d.tcnt = '0;
                    d.oe_n = 1'b0;
                end
            end
            ST_PRES_LOW: begin
                d.tcnt = q.tcnt + TW'(1);
                if (q.tcnt == PRES_CYC - TW'(1)) begin
                    d.st = ST_ROM_CMD;
                    d.oe_n = 1'b1;
                    d.bcnt = '0;
                    d.in_slot = 1'b0;
                end
            end
            ST_ROM_CMD: begin
                if (rx_done) begin
                    d.bidx = '0;
                    d.sub = '0;
                    case (rx_byte)
                        CMD_READ_ID: d.st = ST_ROM_READ;
                        CMD_SELECT_ID: d.st = ST_ROM_MATCH;
                        CMD_SKIP_ID: d.st = ST_FUNC_CMD;
                        CMD_SEARCH_ID: d.st = ST_SEARCH;
                        default: d.st = ST_IDLE;
                    endcase
                end
            end
            ST_ROM_READ: begin
                if (slot_end) begin
                    d.bidx = q.bidx + 6'h1;
                    if (q.bidx == 6'(ID_LAST_BIT)) begin
                        d.st = ST_FUNC_CMD;
                    end
                end
            end
            ST_ROM_MATCH: begin
                if (slot_end) begin
                    d.bidx = q.bidx + 6'h1;
                    if (rx_bit != id_bit) begin
                        d.st = ST_IDLE;
                    end else if (q.bidx == 6'(ID_LAST_BIT)) begin
                        d.st = ST_FUNC_CMD;
                    end
                end
            end
            ST_SEARCH: begin
                if (slot_end) begin
                    d.sub = q.sub + 2'h1;
                    if (q.sub == 2'h2) begin
                        d.sub = '0;
                        d.bidx = q.bidx + 6'h1;
                        if (rx_bit != id_bit) begin
                            d.st = ST_IDLE;
                        end else if (q.bidx == 6'(ID_LAST_BIT)) begin
                            d.st = ST_FUNC_CMD;
                        end
                    end
                end
            end
            ST_FUNC_CMD: begin
                if (rx_done) begin
                    d.bnum = '0;
                    // Store also snapshots, so a short write keeps old bytes
                    req.snap = rx_byte == CMD_FETCH_TIME ||
                               rx_byte == CMD_STORE_TIME;
                    case (rx_byte)
                        CMD_FETCH_TIME: begin
                            d.st = ST_READ_CLK;
                            d.sh = ctrl_byte;
                        end
                        CMD_STORE_TIME: d.st = ST_WRITE_CLK;
                        default: d.st = ST_IDLE;
                    endcase
                end
            end
            ST_READ_CLK: begin
                if (slot_end && q.bcnt == 3'h7) begin
                    // Wrap to the control byte with no fresh snapshot
                    d.bnum = (q.bnum == LAST_CNT_BYTE) ? 3'h0 :
                             q.bnum + 3'h1;
                    d.load = 2'h2;
                end
                if (q.load != 2'h0) begin
                    d.load = q.load - 2'h1;
                end
                if (q.load == 2'h1) begin
                    d.sh = (q.bnum == 3'h0) ? ctrl_byte : buf_rdata;
                end
            end
            ST_WRITE_CLK: begin
                if (rx_done) begin
                    if (q.bnum == 3'h0) begin
                        d.osc = rx_byte[CTRL_OSC_BIT];
                        d.flags = rx_byte[7:CTRL_FLAG_LSB];
                        d.wr_pend = 1'b1;
                    end else if (q.bnum != WR_DONE_BYTE) begin
                        req.we = 1'b1;
                        req.waddr = 2'(q.bnum - 3'h1);
                        req.wdata = rx_byte;
                    end
                    if (q.bnum != WR_DONE_BYTE) begin
                        d.bnum = q.bnum + 3'h1;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase

        // Long low restarts the link and loads a pending write into the clock; flags stay intact
        if (long_low) begin
            d.st = ST_RST_LOW;
            d.in_slot = 1'b0;
            d.oe_n = 1'b1;
            d.load = '0;
            if (q.wr_pend) begin
                d.rtc = buf_word;
                d.wr_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.dq_s1 <= 1'b1;
            q.dq_s2 <= 1'b1;
            q.dq_prev <= 1'b1;
            q.oe_n <= 1'b1;
            q.rtc <= RTC_RESET;
            q.osc <= OSC_RESET;
            q.flags <= FLAGS_RESET;
        end else begin
            q <= d;
        end
    end

    assign dq_out = q.dq_out;
    assign dq_oe_n = q.oe_n;
    assign rtc_count = q.rtc;
    assign osc_run = q.osc;
    assign user_flag_bits = q.flags;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_fetch_cmd;
        q.st == ST_FUNC_CMD && rx_done && rx_byte == CMD_FETCH_TIME;
    endsequence

    sequence s_reset_end;
        q.st == ST_RST_LOW && q.dq_s2;
    endsequence

    a_fetch_snap: assert property (
        s_fetch_cmd |=> q.st == ST_READ_CLK && q.sh == $past(ctrl_byte)
            && buf_word == $past(q.rtc))
        else $error("fetch did not snapshot counter");

    a_read_bytes: assert property (
        q.st == ST_READ_CLK && q.load == 2'h1 && q.bnum != 3'h0
            && !long_low
        |=> q.sh == $past(buf_word[8*(q.bnum-3'h1) +: 8]))
        else $error("counter byte sent out of order");

    a_no_resnap: assert property (
        q.st == ST_READ_CLK |=> $stable(buf_word))
        else $error("snapshot retaken during fetch");

    a_reset_abort: assert property (
        long_low |=> q.st == ST_RST_LOW && q.oe_n)
        else $error("long low did not abort transfer");

    a_ctrl_apply: assert property (
        q.st == ST_WRITE_CLK && rx_done && q.bnum == 3'h0
        |=> q.osc == $past(rx_byte[3]) && q.flags == $past(rx_byte[7:4]))
        else $error("control byte not applied");

    a_commit_reset: assert property (
        long_low && q.wr_pend |=> q.rtc == $past(buf_word) && !q.wr_pend)
        else $error("shadow not committed on reset");

    a_osc_hold: assert property (
        !q.osc && !long_low |=> $stable(q.rtc))
        else $error("stopped counter changed");

    a_presence_seq: assert property (
        s_reset_end |=> q.st == ST_PRES_WAIT && q.oe_n [*8])
        else $error("presence driven too early");

    a_presence_end: assert property (
        q.st == ST_PRES_LOW && q.tcnt == PRES_CYC - TW'(1) && !long_low
        |=> q.st == ST_ROM_CMD && q.oe_n)
        else $error("presence pulse length wrong");

    a_search_drop: assert property (
        q.st == ST_SEARCH && slot_end && q.sub == 2'h2 && rx_bit != id_bit
            && !long_low
        |=> q.st == ST_IDLE)
        else $error("search did not drop out");

    a_zero_hold: assert property (
        $fell(q.oe_n) && q.st != ST_PRES_LOW |-> q.in_slot && q.tcnt == '0)
        else $error("line driven outside a read slot");

endmodule

// >>> core/swrtc_pkg.sv
// Purpose: Shared constants, types and state layout of the single-wire
//          seconds-clock slave.
// Assumes: 40 MHz system clock, battery-domain reset.
// Notes:   Every time is kept in microseconds and turned into cycles here.
package swrtc_pkg;

    localparam int CLK_MHZ = 40;
    localparam int TW = 16;

    // Long-low detection point and presence timing
    localparam int RESET_DET_US = 480;
    localparam int PRES_WAIT_US = 30;
    localparam int PRES_LOW_US = 120;
    // Write-slot sample point and read-zero hold time
    localparam int SAMPLE_US = 30;
    localparam int HOLD_US = 30;

    localparam int RESET_DET_CYC = RESET_DET_US * CLK_MHZ;
    localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
    localparam logic [TW-1:0] PRES_WAIT_CYC = TW'(PRES_WAIT_US * CLK_MHZ);
    localparam logic [TW-1:0] SAMPLE_CYC = TW'(SAMPLE_US * CLK_MHZ);
    localparam logic [TW-1:0] HOLD_CYC = TW'(HOLD_US * CLK_MHZ);

    // Identity-selection and clock commands
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_SELECT_ID = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID = 8'hCC;
    localparam logic [7:0] CMD_SEARCH_ID = 8'hF0;
    localparam logic [7:0] CMD_FETCH_TIME = 8'h66;
    localparam logic [7:0] CMD_STORE_TIME = 8'h99;

    // Control byte layout, last identity bit and counter byte limits
    localparam int CTRL_OSC_BIT = 3;
    localparam int CTRL_FLAG_LSB = 4;
    localparam int ID_LAST_BIT = 63;
    localparam logic [2:0] LAST_CNT_BYTE = 3'h4;
    localparam logic [2:0] WR_DONE_BYTE = 3'h5;

    // Values after reset
    localparam logic [31:0] RTC_RESET = 32'h0000_0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic OSC_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RST_LOW, ST_PRES_WAIT, ST_PRES_LOW, ST_ROM_CMD,
        ST_ROM_READ, ST_ROM_MATCH, ST_SEARCH, ST_FUNC_CMD, ST_READ_CLK,
        ST_WRITE_CLK
    } swrtc_state_t;

    typedef struct packed {
        logic snap;
        logic [31:0] snap_val;
        logic we;
        logic [1:0] waddr;
        logic [7:0] wdata;
        logic [1:0] raddr;
    } swrtc_buf_req_t;

    typedef struct packed {
        swrtc_state_t st;
        logic dq_s1;
        logic dq_s2;
        logic dq_prev;
        logic [TW-1:0] low_cnt;
        logic [TW-1:0] tcnt;
        logic in_slot;
        logic oe_n;
        logic dq_out;
        logic [2:0] bcnt;
        logic [5:0] bidx;
        logic [1:0] sub;
        logic [2:0] bnum;
        logic [7:0] sh;
        logic [1:0] load;
        logic wr_pend;
        logic [31:0] rtc;
        logic osc;
        logic [3:0] flags;
    } swrtc_regs_t;

endpackage

// >>> core/swrtc_shadow.sv
// Purpose: Four-byte shadow read/write buffer between bus and counter.
// Assumes: Snapshot and byte write never needed in the same cycle.
// Notes:   Read data are registered, so they trail raddr by one cycle.
`timescale 1ns/100ps
module swrtc_shadow
    import swrtc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire swrtc_buf_req_t req,
    output logic [7:0] rdata,
    output logic [31:0] word
);

    typedef struct packed {
        logic [3:0][7:0] bytes;
        logic [7:0] rdata;
    } swrtc_shadow_t;

    swrtc_shadow_t q;
    swrtc_shadow_t d;

    always_comb begin
        d = q;
        for (int i = 0; i < 4; i++) begin
            if (req.snap) begin
                d.bytes[i] = req.snap_val[8*i +: 8];
            end else if (req.we && req.waddr == 2'(i)) begin
                d.bytes[i] = req.wdata;
            end
        end
        d.rdata = q.bytes[req.raddr];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign word = q.bytes;

endmodule

// >>> testbench/swrtc_master_model.sv
// Purpose: Behavioural bus master for the single-wire seconds-clock slave.
// Assumes: Tasks are entered just after a rising clk edge.
// Notes:   Slot lengths are shortened; write-0 lows stay just past the
//          sample point and below the long-low count set in the bench.
`timescale 1ns/100ps
module swrtc_master_model (
    input wire logic clk,
    input wire logic line,
    output logic rel_q
);
    localparam int RST_LOW = 1280;
    localparam int SLOT = 1215;
    // Released line idles high through the pull-up
    initial rel_q = 1'b1;

    task automatic hold(input logic v, input int n);
        rel_q <= v;
        repeat (n) @(posedge clk);
    endtask

    // Long low, release, then time the first low seen on the line
    task automatic reset_pulse(output int at);
        hold(1'b0, RST_LOW);
        hold(1'b1, 0);
        at = -1;
        for (int i = 0; i < 1340; i++) begin
            @(posedge clk);
            if (!line && at < 0) begin
                at = i;
            end
        end
    endtask

    // Every slot opens with a master low
    task automatic write_bit(input logic b);
        if (b) begin
            hold(1'b0, 8);
            hold(1'b1, SLOT - 8);
        end else begin
            hold(1'b0, 1208);
            hold(1'b1, SLOT - 1208);
        end
    endtask

    // Sample near mid-slot, after the device has had time to pull
    task automatic read_bit(output logic b);
        hold(1'b0, 4);
        hold(1'b1, 600);
        b = line;
        repeat (SLOT - 604) @(posedge clk);
    endtask

    // Commands follow presence, one whole byte each
    task automatic write_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            write_bit(v[i]);
        end
    endtask

    task automatic read_bits(input int n, output logic [7:0] v);
        logic b;
        v = 8'h00;
        for (int i = 0; i < n; i++) begin
            read_bit(b);
            v[i] = b;
        end
    endtask
endmodule

// >>> testbench/single_wire_rtc_slave_tb.sv
// Purpose: Self-checking bench for the single-wire seconds-clock slave.
// Assumes: 40 MHz clock, shortened long-low and presence counts.
// Notes:   Identity commands with 64-bit traffic are left out to keep
//          the run short; skip-selection carries the clock commands.
`timescale 1ns/100ps
module single_wire_rtc_slave_tb;
    import swrtc_pkg::*;

`define CHK(nm, ex, gt) \
    begin \
        check_count++; \
        if ((gt) !== (ex)) begin \
            fails++; \
            $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
        end \
    end

    logic clk;
    logic rst_n;
    logic sec_tick;
    logic dq_out;
    logic dq_oe_n;
    logic rel_q;
    wire logic line;
    logic [31:0] rtc_count;
    logic osc_run;
    logic [3:0] user_flag_bits;
    int fails = 0;
    int check_count = 0;

    // Open-drain wire: either party pulling makes it low
    assign line = rel_q & (dq_oe_n ? 1'b1 : dq_out);

    swrtc_slave #(
        .RESET_CYC(16'h04E2),
        .PRES_CYC(16'h0064)
    ) uut (
        .clk(clk),
        .rst_n(rst_n),
        .dq_in(line),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .sec_tick(sec_tick),
        .rtc_count(rtc_count),
        .osc_run(osc_run),
        .user_flag_bits(user_flag_bits)
    );

    swrtc_master_model master (
        .clk(clk),
        .line(line),
        .rel_q(rel_q)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick();
        sec_tick <= 1'b1;
        @(posedge clk);
        sec_tick <= 1'b0;
        @(posedge clk);
    endtask

    // Presence must start inside the allowed wait window
    task automatic init_seq();
        int at;
        master.reset_pulse(at);
        `CHK("presence", 1'b1, (at >= 600 && at <= 1600))
    endtask

    task automatic t_reset_values();
        `CHK("oe_n idle", 1'b1, dq_oe_n)
        `CHK("dq_out low", 1'b0, dq_out)
        `CHK("osc off", 1'b0, osc_run)
        tick();
        `CHK("stopped count", 32'h0000_0000, rtc_count)
    endtask

    // Control byte takes hold at once; one counter byte only, the rest
    // keep the snapshot taken at the command
    task automatic t_store();
        init_seq();
        master.write_byte(CMD_SKIP_ID);
        master.write_byte(CMD_STORE_TIME);
        master.write_byte(8'hA8);
        `CHK("osc on", 1'b1, osc_run)
        `CHK("flags", 4'hA, user_flag_bits)
        master.write_byte(8'h5C);
        `CHK("no early commit", 32'h0000_0000, rtc_count)
        init_seq();
        `CHK("commit", 32'h0000_005C, rtc_count)
        `CHK("flags kept", 4'hA, user_flag_bits)
        `CHK("osc kept", 1'b1, osc_run)
        tick();
        `CHK("counting", 32'h0000_005D, rtc_count)
    endtask

    // A tick after the command must not reach the bytes read back
    task automatic t_fetch();
        logic [7:0] v;
        init_seq();
        master.write_byte(CMD_SKIP_ID);
        master.write_byte(CMD_FETCH_TIME);
        master.read_bits(8, v);
        `CHK("ctrl byte", 8'hAC, v)
        master.read_bits(8, v);
        `CHK("byte0", 8'h5D, v)
        tick();
        master.read_bits(8, v);
        `CHK("byte1", 8'h00, v)
        `CHK("live count", 32'h0000_005E, rtc_count)
        master.read_bits(2, v);
        `CHK("byte2 part", 8'h00, v)
        init_seq();
        `CHK("released", 1'b1, dq_oe_n)
    endtask

    initial begin
        rst_n = 1'b0;
        sec_tick = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset_values();
        t_store();
        t_fetch();
        end_of_test();
    end

    // Expected run is near 100.4k cycles; allow some slack
    initial begin
        repeat (110000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
